// ### bench/mau_core_tb_top.sv
// Self-checking bench for the math datapath
`timescale 1ns/100ps
module mau_core_tb_top;
    localparam logic [1:0] W = mau_pkg::DT_WORD, L = mau_pkg::DT_LONG, F = mau_pkg::DT_FLOAT;
    localparam logic [2:0] MU = mau_pkg::OP_MULTIPLY, DV = mau_pkg::OP_DIVIDE;
    localparam logic [2:0] NG = mau_pkg::OP_NEGATE, CL = mau_pkg::OP_CLEAR;
    localparam logic [2:0] AB = mau_pkg::OP_ABSOLUTE;
    localparam logic [1:0] RC = mau_pkg::REG_CTRL, RS = mau_pkg::REG_STAT;
    localparam logic [1:0] RM = mau_pkg::REG_MATH, RQ = mau_pkg::REG_QUOT;
    logic        clk, rstn, ce, req, start, ready, done, dest_math_reg, reg_wr, reg_rd;
    logic        carry_flag, ovf_flag, zero_flag, sign_flag, trap_flag, lt;
    logic        rd_d = 1'b0;
    logic [1:0]  type_a, type_b, type_d, reg_addr;
    logic [2:0]  op;
    logic [4:0]  lf;
    logic [31:0] opnd_a, opnd_b, dest, reg_wdata, reg_rdata, x, y;
    logic [73:0] cmd;
    logic [37:0] e;
    logic [36:0] g;
    logic [37:0] q[$];
    int          mismatches = 0;
    int          n_checks = 0;

    mau_seq seq (.clk(clk), .rstn(rstn), .req(req), .cmd(cmd), .ready(ready), .start(start),
        .op(op), .type_a(type_a), .type_b(type_b), .type_d(type_d), .opnd_a(opnd_a),
        .opnd_b(opnd_b), .dest_math_reg(dest_math_reg));
    mau_core dut (.clk(clk), .rstn(rstn), .ce(ce), .start(start), .op(op), .type_a(type_a),
        .type_b(type_b), .type_d(type_d), .opnd_a(opnd_a), .opnd_b(opnd_b),
        .dest_math_reg(dest_math_reg), .ready(ready), .done(done), .dest(dest),
        .carry_flag(carry_flag), .ovf_flag(ovf_flag), .zero_flag(zero_flag),
        .sign_flag(sign_flag), .trap_flag(trap_flag), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic report_and_stop;
        // Results that never showed up are failures too
        if (q.size() != 0) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, q.size(), 32'h0);
        end
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Long divide rounds half to even on the remainder
    function automatic logic [31:0] divr(input logic [31:0] a, b);
        logic [31:0] qq;
        logic [31:0] r;
        qq = a / b;
        r = a % b;
        if (2 * r > b || (2 * r == b && qq[0])) qq = qq + 32'h1;
        return qq;
    endfunction

    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [31:0] ex);
        q.push_back({1'b1, ex, 5'h0});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask

    // co is {overflow, carry}; flags are compared only when cf is set
    task automatic run(input logic [2:0] o, input logic [1:0] ta, td,
                       input logic [31:0] a, b, ed, input logic mr,
                       input logic [1:0] co, input logic cf);
        int i;
        if (cf) begin
            lt = lt | co[1];
            lf = {lt, (td == W) ? ed[15] : ed[31], ed == 32'h0, co};
        end
        q.push_back({cf, ed, lf});
        cmd <= {o, ta, ta, td, a, b, mr};
        req <= 1'b1;
        for (i = 0; i < 9 && start !== 1'b1; i++) @(posedge clk);
        req <= 1'b0;
        for (i = 0; i < 50 && done !== 1'b1; i++) @(posedge clk);
        n_checks++;
        if (done !== 1'b1 || ready !== 1'b1) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, {done, ready}, 2'h3);
        end
    endtask

    task automatic tend(input string s);
        $display("test %s finished, %0d checks so far", s, n_checks);
    endtask

    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d || done === 1'b1) begin
            e = q.pop_front();
            g = rd_d ? {reg_rdata, 5'h0}
                     : {dest, trap_flag, sign_flag, zero_flag, ovf_flag, carry_flag};
            if (!e[37]) g[4:0] = e[4:0];
            n_checks++;
            if (g !== e[36:0]) begin
                mismatches++;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e[36:0]);
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        {rstn, req, reg_wr, reg_rd, lt, lf, cmd, reg_addr, reg_wdata} = '0;
        ce = 1'b1;
        void'($urandom(32'h5CB7));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(RC, 32'h0);
        rd(RS, 32'h0);
        tend("reset");
        wr(RC, 32'h0);
        run(AB, W, W, 32'hFFFB, 0, 32'h5, 0, 2'b01, 1);
        run(AB, W, W, 32'h8000, 0, 32'h7FFF, 0, 2'b11, 1);
        run(AB, L, L, 32'h8000_0000, 0, 32'h7FFF_FFFF, 0, 2'b11, 1);
        run(AB, L, W, 32'h0, 0, 32'h0, 0, 2'b00, 1);
        rd(RS, {27'h0, lf});
        wr(RC, 32'h1);
        rd(RC, 32'h1);
        run(AB, W, W, 32'h8000, 0, 32'h8000, 0, 2'b11, 1);
        run(AB, L, W, 32'h0001_2345, 0, 32'h2345, 0, 2'b10, 1);
        run(AB, F, F, 32'hBFC0_0000, 0, 32'h3FC0_0000, 0, 2'b00, 1);
        run(AB, F, W, 32'hFF80_0000, 0, 32'h7FFF, 0, 2'b10, 1);
        run(AB, F, L, 32'h4020_0000, 0, 32'h2, 0, 2'b00, 1);
        run(AB, F, W, 32'h4060_0000, 0, 32'h4, 0, 2'b00, 1);
        run(AB, F, W, 32'hC700_0000, 0, 32'h7FFF, 0, 2'b10, 1);
        run(AB, F, F, 32'h7FC0_0001, 0, 32'h7FC0_0001, 0, 2'b10, 1);
        run(AB, W, F, 32'hFFFD, 0, 32'h4040_0000, 0, 2'b00, 1);
        wr(RS, 32'h10);
        lt = 1'b0;
        lf[4] = 1'b0;
        rd(RS, {27'h0, lf});
        run(AB, W, W, 32'h7FFF, 0, 32'h7FFF, 0, 2'b00, 1);
        tend("absolute");
        wr(RC, 32'h0);
        repeat (4) begin
            x = $urandom;
            y = $urandom;
            x = {{16{x[15]}}, x[15:0]};
            y = {{16{y[15]}}, y[15:0]};
            run(MU, L, L, x, y, x * y, 0, 2'b00, 0);
            x = $urandom & 32'h7FFF_FFFF;
            y = $urandom_range(1000, 1);
            run(DV, L, L, x, y, divr(x, y), 0, 2'b00, 0);
        end
        run(MU, W, W, 32'h64, 32'hFFFD, 32'hFED4, 0, 2'b00, 0);
        run(DV, L, L, 32'h5, 32'h2, 32'h2, 0, 2'b00, 0);
        run(DV, W, W, 32'h7, 32'h2, 32'h3, 0, 2'b00, 0);
        run(DV, W, W, 32'h11, 32'h5, 32'h2, 1, 2'b00, 0);
        rd(RQ, 32'h3);
        rd(RM, 32'h2);
        run(NG, L, L, 32'h5, 0, 32'hFFFF_FFFB, 0, 2'b00, 0);
        run(NG, W, W, 32'h5, 0, 32'hFFFB, 0, 2'b00, 0);
        run(NG, F, F, 32'h3FC0_0000, 0, 32'hBFC0_0000, 0, 2'b00, 0);
        run(CL, L, L, $urandom, 0, 32'h0, 0, 2'b00, 0);
        run(CL, W, W, $urandom, 0, 32'h0, 0, 2'b00, 0);
        tend("arithmetic");
        // A write while the enable is low must be lost
        ce <= 1'b0;
        wr(RC, 32'h1);
        ce <= 1'b1;
        rd(RC, 32'h0);
        // Reset right after a control write, with no operation running, clears control and status
        wr(RC, 32'h1);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rd(RC, 32'h0);
        rd(RS, 32'h0);
        tend("freeze and reset");
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule

// ### bench/mau_seq.sv
// Sequencer model that issues one math operation per bench request
`timescale 1ns/100ps
module mau_seq (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Request from the bench
    input  wire logic        req,
    input  wire logic [73:0] cmd,
    // Operation issue
    input  wire logic        ready,
    output logic             start,
    output logic [2:0]       op,
    output logic [1:0]       type_a,
    output logic [1:0]       type_b,
    output logic [1:0]       type_d,
    output logic [31:0]      opnd_a,
    output logic [31:0]      opnd_b,
    output logic             dest_math_reg
);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start <= 1'b0;
            {op, type_a, type_b, type_d, opnd_a, opnd_b, dest_math_reg} <= '0;
        end else if (req && ready && !start) begin
            start <= 1'b1;
            {op, type_a, type_b, type_d, opnd_a, opnd_b, dest_math_reg} <= cmd;
        end else begin
            start <= 1'b0;
            // Stale after the take edge; scrambled so late sampling shows
            opnd_a <= ~opnd_a;
            opnd_b <= ~opnd_b;
        end
    end
endmodule

// ### core/mau_core.sv
// Math datapath: multiply, divide, negate, clear and absolute value
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module mau_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Operation issue
    input  wire logic        start,
    input  wire logic [2:0]  op,
    input  wire logic [1:0]  type_a,
    input  wire logic [1:0]  type_b,
    input  wire logic [1:0]  type_d,
    input  wire logic [31:0] opnd_a,
    input  wire logic [31:0] opnd_b,
    input  wire logic        dest_math_reg,
    output logic             ready,
    output logic             done,
    output logic [31:0]      dest,
    // Status bits
    output logic             carry_flag,
    output logic             ovf_flag,
    output logic             zero_flag,
    output logic             sign_flag,
    output logic             trap_flag,
    // Register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} mau_state_t;

    // Sign-extend an integer operand to 32 bits
    function automatic logic [31:0] sx(input logic [31:0] v, input logic [1:0] dt);
        return (dt == mau_pkg::DT_WORD) ? {{16{v[mau_pkg::WORD_MSB]}}, v[15:0]} : v;
    endfunction

    // Positive or negative saturation value for a destination type
    function automatic logic [31:0] sat_of(input logic [1:0] dt, input logic minus);
        if (dt == mau_pkg::DT_WORD) begin
            return minus ? (mau_pkg::MIN_WORD & mau_pkg::WORD_MASK) : mau_pkg::SAT_WORD;
        end
        return minus ? mau_pkg::MIN_LONG : mau_pkg::SAT_LONG;
    endfunction

    // Fit a signed value into the destination: {overflow, stored value}
    function automatic logic [32:0] fit_int(input logic signed [63:0] v,
                                            input logic [1:0] dt, input logic trunc);
        logic signed [63:0] hi;
        logic signed [63:0] lo;
        logic               o;
        logic [31:0]        r;
        hi = (dt == mau_pkg::DT_WORD) ? 64'($signed(mau_pkg::SAT_WORD))
                                      : 64'($signed(mau_pkg::SAT_LONG));
        lo = (dt == mau_pkg::DT_WORD) ? 64'($signed(mau_pkg::MIN_WORD))
                                      : 64'($signed(mau_pkg::MIN_LONG));
        o  = (v > hi) || (v < lo);
        r  = (o && !trunc) ? sat_of(dt, v[63]) : v[31:0];
        if (dt == mau_pkg::DT_WORD) begin
            r = r & mau_pkg::WORD_MASK;
        end
        return {o, r};
    endfunction

    // Float magnitude to rounded integer; bit 32 marks a value too big
    function automatic logic [32:0] f2i(input logic [31:0] f);
        logic [7:0]  e;
        logic [55:0] x;
        logic [32:0] ip;
        logic        up;
        e  = f[mau_pkg::F_EXP_HI:mau_pkg::F_EXP_LO];
        x  = {1'h1, f[mau_pkg::F_EXP_LO-1:0], 32'h0} >> (mau_pkg::F_LSB_EXP - e);
        ip = {9'h0, x[55:32]};
        up = x[31] & ((|x[30:0]) | ip[0]);
        if (e >= mau_pkg::F_BIG_EXP) begin
            return {1'h1, 32'h0};
        end
        // Denormals and tiny values round to zero
        if (e < mau_pkg::F_TINY_EXP) begin
            return 33'h0;
        end
        if (e >= mau_pkg::F_LSB_EXP) begin
            return 33'({1'h1, f[mau_pkg::F_EXP_LO-1:0]}) << (e - mau_pkg::F_LSB_EXP);
        end
        return ip + 33'(up);
    endfunction

    // Unsigned integer to positive float, rounded half to even
    function automatic logic [31:0] i2f(input logic [31:0] m);
        logic [31:0] n;
        logic [7:0]  lz;
        logic        up;
        n  = m;
        lz = 8'h0;
        for (int i = 0; i < mau_pkg::LONG_MSB; i++) begin
            if (!n[mau_pkg::LONG_MSB]) begin
                n  = n << 1;
                lz = lz + 8'h1;
            end
        end
        up = n[mau_pkg::F_GUARD] & ((|n[mau_pkg::F_GUARD-1:0]) | n[mau_pkg::F_GUARD+1]);
        if (m == 32'h0) begin
            return 32'h0;
        end
        // A mantissa carry rolls into the exponent on its own
        return {1'h0, mau_pkg::F_TOP_EXP - lz, n[30:mau_pkg::F_GUARD+1]} + 32'(up);
    endfunction

    mau_state_t  st;
    mau_state_t  next_st;
    logic [2:0]  op_q;
    logic [1:0]  ta;
    logic [1:0]  tb;
    logic [1:0]  td;
    logic [31:0] a_q;
    logic [31:0] b_q;
    logic        mr_q;
    logic        ovf_sel;
    logic [31:0] math_reg;
    logic [31:0] quot_reg;
    logic [31:0] next_res;
    logic        next_ovf;
    logic        next_cy;
    logic        div_fin;
    logic [31:0] div_q;
    logic [31:0] div_r;

    // Operand decode
    wire logic [31:0] ai       = sx(a_q, ta);
    wire logic [31:0] bi       = sx(b_q, tb);
    wire logic        a_minus  = ai[mau_pkg::LONG_MSB];
    wire logic        b_minus  = bi[mau_pkg::LONG_MSB];
    wire logic [31:0] a_mag    = a_minus ? 32'(-ai) : ai;
    wire logic [31:0] b_mag    = b_minus ? 32'(-bi) : bi;
    wire logic        a_flt    = (ta == mau_pkg::DT_FLOAT);
    wire logic        d_flt    = (td == mau_pkg::DT_FLOAT);
    wire logic [7:0]  a_exp    = a_q[mau_pkg::F_EXP_HI:mau_pkg::F_EXP_LO];
    wire logic        a_special = (a_exp == mau_pkg::F_EXP_MAX);
    wire logic [31:0] d_limit  = (td == mau_pkg::DT_WORD) ? mau_pkg::SAT_WORD : mau_pkg::SAT_LONG;

    // Command handshake
    assign ready = (st == ST_IDLE);
    wire logic take   = ce && start && ready;
    wire logic div_go = ce && (st == ST_EXEC) && (op_q == mau_pkg::OP_DIVIDE);
    wire logic finish = ce && (((st == ST_EXEC) && (op_q != mau_pkg::OP_DIVIDE)) ||
                               ((st == ST_WAIT) && div_fin));

    mau_div #(
        .W (mau_pkg::DIV_W)
    ) u_div (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .go   (div_go),
        .num  (a_mag),
        .den  (b_mag),
        .fin  (div_fin),
        .quo  (div_q),
        .rem  (div_r)
    );

    // Divide result shaping
    wire logic        word_div = (ta == mau_pkg::DT_WORD) && (tb == mau_pkg::DT_WORD);
    wire logic        math_div = word_div && mr_q;
    wire logic [32:0] r2       = {div_r, 1'h0};
    wire logic        rnd_up   = !word_div && ((r2 > {1'h0, b_mag}) ||
                                 ((r2 == {1'h0, b_mag}) && div_q[0]));
    wire logic [32:0] q_rnd    = {1'h0, div_q} + 33'(rnd_up);
    wire logic [63:0] q_pos    = {31'h0, q_rnd};
    wire logic [63:0] q_val    = (a_minus ^ b_minus) ? 64'(-q_pos) : q_pos;
    wire logic [31:0] r_val    = (a_minus ? 32'(-div_r) : div_r) & mau_pkg::WORD_MASK;
    wire logic [31:0] q_word   = 32'(q_val) & mau_pkg::WORD_MASK;

    // Float to integer path shared by conversion cases
    wire logic [32:0] f_int    = f2i(a_q);
    wire logic        f_big    = a_special || f_int[32] || (f_int[31:0] > d_limit);

    always_comb begin
        next_res = 32'h0;
        next_ovf = 1'h0;
        next_cy  = 1'h0;
        unique case (op_q)
            mau_pkg::OP_MULTIPLY: begin
                {next_ovf, next_res} = fit_int(64'($signed(ai)) * 64'($signed(bi)),
                                               td, ovf_sel);
            end
            mau_pkg::OP_DIVIDE: begin
                if (b_mag == 32'h0) begin
                    next_ovf = 1'h1;
                    next_res = ovf_sel ? 32'h0 : sat_of(td, a_minus);
                end else if (math_div) begin
                    next_res = r_val;
                end else begin
                    {next_ovf, next_res} = fit_int(q_val, td, ovf_sel);
                end
            end
            mau_pkg::OP_NEGATE: begin
                if (a_flt) begin
                    next_res = a_q ^ mau_pkg::F_SIGN_BIT;
                    next_ovf = a_special;
                end else begin
                    {next_ovf, next_res} = fit_int(-64'($signed(ai)), td, ovf_sel);
                end
            end
            mau_pkg::OP_CLEAR: begin
                next_res = 32'h0;
            end
            mau_pkg::OP_ABSOLUTE: begin
                if (a_flt && d_flt) begin
                    next_res = a_q & ~mau_pkg::F_SIGN_BIT;
                    next_ovf = a_special;
                end else if (a_flt) begin
                    next_res = f_big ? d_limit : f_int[31:0];
                    next_ovf = f_big;
                end else if (d_flt) begin
                    next_res = i2f(a_mag);
                end else begin
                    {next_ovf, next_res} = fit_int({32'h0, a_mag}, td, ovf_sel);
                    next_cy  = a_minus;
                end
            end
            default: begin
                next_res = 32'h0;
            end
        endcase
    end

    // Flags of the destination as written
    wire logic next_zero = (next_res == 32'h0);
    wire logic next_sign = (td == mau_pkg::DT_WORD) ? next_res[mau_pkg::WORD_MSB] :
                                                      next_res[mau_pkg::LONG_MSB];

    // Register port decode
    wire logic wr_ctrl = ce && reg_wr && (reg_addr == mau_pkg::REG_CTRL);
    wire logic wr_stat = ce && reg_wr && (reg_addr == mau_pkg::REG_STAT);
    wire logic wipe    = wr_stat && reg_wdata[mau_pkg::STAT_TRAP];
    // Setting wins over a software wipe in the same cycle
    wire logic next_trap = (finish && next_ovf) || (trap_flag && !wipe);
    wire logic [31:0] stat_word = {27'h0, trap_flag, sign_flag, zero_flag,
                                   ovf_flag, carry_flag};
    wire logic [31:0] rd_word = (reg_addr == mau_pkg::REG_CTRL) ? {31'h0, ovf_sel} :
                                (reg_addr == mau_pkg::REG_STAT) ? stat_word :
                                (reg_addr == mau_pkg::REG_MATH) ? math_reg : quot_reg;

    always_comb begin
        next_st = st;
        unique case (st)
            ST_IDLE: if (take) next_st = ST_EXEC;
            ST_EXEC: next_st = (op_q == mau_pkg::OP_DIVIDE) ? ST_WAIT : ST_IDLE;
            ST_WAIT: if (div_fin) next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= ST_IDLE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            op_q <= mau_pkg::OP_CLEAR;
            ta   <= mau_pkg::DT_WORD;
            tb   <= mau_pkg::DT_WORD;
            td   <= mau_pkg::DT_WORD;
            a_q  <= 32'h0;
            b_q  <= 32'h0;
            mr_q <= 1'h0;
        end else if (take) begin
            op_q <= op;
            ta   <= type_a;
            tb   <= type_b;
            td   <= type_d;
            a_q  <= opnd_a;
            b_q  <= opnd_b;
            mr_q <= dest_math_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done       <= 1'h0;
            dest       <= 32'h0;
            carry_flag <= 1'h0;
            ovf_flag   <= 1'h0;
            zero_flag  <= 1'h0;
            sign_flag  <= 1'h0;
        end else if (ce) begin
            done <= finish;
            if (finish) begin
                dest       <= next_res;
                carry_flag <= next_cy;
                ovf_flag   <= next_ovf;
                zero_flag  <= next_zero;
                sign_flag  <= next_sign;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trap_flag <= 1'h0;
            ovf_sel   <= 1'h0;
            math_reg  <= 32'h0;
            quot_reg  <= 32'h0;
            reg_rdata <= 32'h0;
        end else if (ce) begin
            trap_flag <= next_trap;
            if (wr_ctrl) begin
                ovf_sel <= reg_wdata[mau_pkg::CTRL_OVF_SEL];
            end
            if (finish && (op_q == mau_pkg::OP_DIVIDE) && math_div && (b_mag != 32'h0)) begin
                math_reg <= r_val;
                quot_reg <= q_word;
            end
            reg_rdata <= reg_rd ? rd_word : 32'h0;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_clear;
        done && (op_q == mau_pkg::OP_CLEAR) |-> (dest == 32'h0) && !ovf_flag && zero_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left nonzero");

    property p_trap;
        done && ovf_flag |-> trap_flag;
    endproperty
    a_trap: assert property (p_trap) else $error("trap missed overflow");

    property p_trap_keep;
        trap_flag && !wipe |=> trap_flag;
    endproperty
    a_trap_keep: assert property (p_trap_keep) else $error("trap dropped");

    property p_zero;
        done |-> zero_flag == (dest == 32'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sign;
        done && (td == mau_pkg::DT_WORD) |-> sign_flag == dest[mau_pkg::WORD_MSB];
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");

    property p_fcarry;
        done && (op_q == mau_pkg::OP_ABSOLUTE) && (a_flt || d_flt) |-> !carry_flag;
    endproperty
    a_fcarry: assert property (p_fcarry) else $error("carry set on float");

    property p_fsign;
        done && (op_q == mau_pkg::OP_ABSOLUTE) && a_flt && d_flt
            |-> dest == (a_q & ~mau_pkg::F_SIGN_BIT);
    endproperty
    a_fsign: assert property (p_fsign) else $error("float magnitude wrong");

    property p_sat;
        done && (op_q == mau_pkg::OP_ABSOLUTE) && !a_flt && !d_flt && !ovf_sel && ovf_flag
            |-> dest == d_limit;
    endproperty
    a_sat: assert property (p_sat) else $error("saturation wrong");

    property p_mul;
        done && (op_q == mau_pkg::OP_MULTIPLY) && (td == mau_pkg::DT_LONG) && !ovf_flag
            |-> dest == 32'(64'($signed(ai)) * 64'($signed(bi)));
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");

    property p_done;
        take |-> ##[2:36] done;
    endproperty
    a_done: assert property (p_done) else $error("operation never done");
endmodule

// ### core/mau_div.sv
// Sequential restoring divider for unsigned magnitudes
`timescale 1ns/100ps
module mau_div #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // Request
    input  wire logic         go,
    input  wire logic [W-1:0] num,
    input  wire logic [W-1:0] den,
    // Answer
    output logic              fin,
    output logic [W-1:0]      quo,
    output logic [W-1:0]      rem
);
    localparam int CW = $clog2(W) + 1;

    if (W < 2) begin : g_bad
        $error("mau_div: W must be at least 2");
    end

    logic [CW-1:0] cnt;
    logic          run;
    logic [W-1:0]  dvs;

    // One quotient bit per cycle keeps the area small
    wire logic [W:0] pr  = {rem, quo[W-1]};
    wire logic       ge  = pr >= {1'h0, dvs};
    wire logic [W:0] dif = pr - {1'h0, dvs};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            run <= 1'h0;
            dvs <= '0;
            fin <= 1'h0;
            quo <= '0;
            rem <= '0;
        end else if (ce) begin
            fin <= 1'h0;
            if (go) begin
                rem <= '0;
                quo <= num;
                dvs <= den;
                cnt <= CW'(W);
                run <= 1'h1;
            end else if (run) begin
                rem <= ge ? dif[W-1:0] : pr[W-1:0];
                quo <= {quo[W-2:0], ge};
                cnt <= cnt - 1'h1;
                if (cnt == CW'(1)) begin
                    run <= 1'h0;
                    fin <= 1'h1;
                end
            end
        end
    end
endmodule

// ### core/mau_pkg.sv
// Codes, field layout and limits shared by the math datapath
package mau_pkg;
    // Operand data types
    localparam logic [1:0] DT_WORD  = 2'h0;
    localparam logic [1:0] DT_LONG  = 2'h1;
    localparam logic [1:0] DT_FLOAT = 2'h2;
    // Operations
    localparam logic [2:0] OP_MULTIPLY = 3'h0;
    localparam logic [2:0] OP_DIVIDE   = 3'h1;
    localparam logic [2:0] OP_NEGATE   = 3'h2;
    localparam logic [2:0] OP_CLEAR    = 3'h3;
    localparam logic [2:0] OP_ABSOLUTE = 3'h4;
    // Register port addresses
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam logic [1:0] REG_MATH = 2'h2;
    localparam logic [1:0] REG_QUOT = 2'h3;
    // Register bit positions
    localparam int CTRL_OVF_SEL = 0;
    localparam int STAT_CARRY   = 0;
    localparam int STAT_OVF     = 1;
    localparam int STAT_ZERO    = 2;
    localparam int STAT_SIGN    = 3;
    localparam int STAT_TRAP    = 4;
    // Integer layout and limits
    localparam int          WORD_MSB  = 15;
    localparam int          LONG_MSB  = 31;
    localparam logic [31:0] WORD_MASK = 32'h0000_FFFF;
    localparam logic [31:0] SAT_WORD  = 32'h0000_7FFF;
    localparam logic [31:0] MIN_WORD  = 32'hFFFF_8000;
    localparam logic [31:0] SAT_LONG  = 32'h7FFF_FFFF;
    localparam logic [31:0] MIN_LONG  = 32'h8000_0000;
    // Float layout
    localparam int          F_EXP_HI   = 30;
    localparam int          F_EXP_LO   = 23;
    localparam int          F_GUARD    = 7;
    localparam logic [31:0] F_SIGN_BIT = 32'h8000_0000;
    localparam logic [7:0]  F_EXP_MAX  = 8'hFF;
    localparam logic [7:0]  F_LSB_EXP  = 8'h96;
    localparam logic [7:0]  F_TINY_EXP = 8'h78;
    localparam logic [7:0]  F_BIG_EXP  = 8'h9F;
    localparam logic [7:0]  F_TOP_EXP  = 8'h9E;
    // Divider width
    localparam int DIV_W = 32;
endpackage
